// >>> core/dtc_pkg.sv
// Constants shared by the dual timer/counter: register offsets, field positions,
// reset values, mode encodings and peripheral-cycle timing.
// Assumes an 8-bit register port with a 4-bit word address.
package dtc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_MODE      = 4'h0;
    localparam logic [3:0] ADDR_CONTROL   = 4'h1;
    localparam logic [3:0] ADDR_CLOCK_CTL = 4'h2;
    localparam logic [3:0] ADDR_SCHED_CLK = 4'h3;
    localparam logic [3:0] ADDR_T0_LOW    = 4'h4;
    localparam logic [3:0] ADDR_T0_HIGH   = 4'h5;
    localparam logic [3:0] ADDR_T1_LOW    = 4'h6;
    localparam logic [3:0] ADDR_T1_HIGH   = 4'h7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // Mode register: timer 0 in the low nibble, timer 1 in the high nibble.
    localparam int MODE_T0_LSB  = 0;
    localparam int MODE_T1_LSB  = 4;
    localparam int MODE_CT_BIT  = 2;
    localparam int MODE_GATE    = 3;
    // Control register.
    localparam int CTL_TF1      = 7;
    localparam int CTL_TR1      = 6;
    localparam int CTL_TF0      = 5;
    localparam int CTL_TR0      = 4;
    // Clock control and scheduler clock registers.
    localparam int CKC_T0_FAST  = 0;
    localparam int CKC_T1_FAST  = 1;
    localparam int SCH_DIV_LSB  = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] RST_DIV  = 7'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // Last phase of a peripheral cycle, which spans six timer clock periods.
    localparam logic [2:0] PCY_LAST = 3'h5;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } dtc_mode_e;

endpackage

// >>> core/dtc_pcy_tick.sv
// Timer clock selection and peripheral-cycle tick for one timer.
// Assumes the system clock is the oscillator clock.
`timescale 1ns/100ps
module dtc_pcy_tick (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic fast_clock_sel,
    input  wire logic double_speed_mode,
    output logic      pcy_tick
);
    import dtc_pkg::*;

    logic       half;
    logic [2:0] phase;
    logic       timer_clk_en;

    // The timer clock is the oscillator halved unless double speed is on and
    // the fast select is clear; then it is the oscillator itself.
    assign timer_clk_en = (fast_clock_sel | ~double_speed_mode) ? half : 1'b1;
    assign pcy_tick     = timer_clk_en & (phase == PCY_LAST);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            half  <= 1'b0;
            phase <= 3'h0;
        end else begin
            half <= ~half;
            if (timer_clk_en) begin
                phase <= (phase == PCY_LAST) ? 3'h0 : phase + 3'h1;
            end
        end
    end

endmodule

// >>> core/dtc_pin_sampler.sv
// Two-stage synchroniser and once-per-peripheral-cycle sampler for a pin.
// Assumes the pin is asynchronous to clock.
`timescale 1ns/100ps
module dtc_pin_sampler (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic pin,
    input  wire logic sample_tick,
    output logic      level,
    output logic      fall
);
    logic sync1;
    logic sync2;
    logic last_sample;

    assign level = sync2;
    // A high sample followed by a low one counts once.
    assign fall  = sample_tick & last_sample & ~sync2;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync1       <= 1'b0;
            sync2       <= 1'b0;
            last_sample <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            if (sample_tick) begin
                last_sample <= sync2;
            end
        end
    end

endmodule

// >>> core/dtc_timers.sv
// Dual 16-bit timer/counter with register port, count pins and gate pins.
// Assumes software stops a timer before presetting it or changing its mode.
`timescale 1ns/100ps
module dtc_timers (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       double_speed_mode,
    input  wire logic       count_pin0,
    input  wire logic       count_pin1,
    input  wire logic       external_gate_pin0,
    input  wire logic       external_gate_pin1,
    input  wire logic       timer0_irq_ack,
    input  wire logic       timer1_irq_ack,
    output logic            timer0_irq_req,
    output logic            timer1_irq_req
);
    import dtc_pkg::*;

    // ------------------------------------------------------------------
    // Count step
    // ------------------------------------------------------------------
    // Returns {overflow, high, low} after one increment in the given mode.
    function automatic logic [16:0] dtc_step(input dtc_mode_e mode,
                                             input logic [7:0] th,
                                             input logic [7:0] tl,
                                             input logic inc);
        logic [16:0] r;
        logic [5:0]  low5;
        logic [8:0]  low8;
        logic [8:0]  high8;
        logic [16:0] full;
        r     = {1'b0, th, tl};
        low5  = {1'b0, tl[4:0]} + 6'h01;
        low8  = {1'b0, tl} + 9'h001;
        high8 = {1'b0, th} + 9'h001;
        full  = {1'b0, th, tl} + 17'h00001;
        if (inc) begin
            case (mode)
                MODE_13BIT: begin
                    // The upper three low bits are left as they are.
                    if (low5[5]) begin
                        r = {high8[8], high8[7:0], tl[7:5], 5'h00};
                    end else begin
                        r = {1'b0, th, tl[7:5], low5[4:0]};
                    end
                end
                MODE_16BIT:  r = full;
                MODE_RELOAD: begin
                    // High byte is read at the moment of reload.
                    r = low8[8] ? {1'b1, th, th} : {1'b0, th, low8[7:0]};
                end
                MODE_SPLIT:  r = {low8[8], th, low8[7:0]};
                default:     r = {1'b0, th, tl};
            endcase
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] timer_mode_register;
    logic [7:0] timer_control_register;
    logic [7:0] clock_control_register;
    logic [7:0] scheduler_clock_register;
    logic [7:0] timer0_count_low;
    logic [7:0] timer0_count_high;
    logic [7:0] timer1_count_low;
    logic [7:0] timer1_count_high;
    logic [6:0] div_count;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    dtc_mode_e  mode0;
    dtc_mode_e  mode1;
    logic       timer0_gate_select;
    logic       timer0_counter_select;
    logic       timer1_gate_select;
    logic       timer1_counter_select;
    logic       timer0_run_bit;
    logic       timer1_run_bit;
    logic       timer0_overflow_flag;
    logic       timer1_overflow_flag;
    logic [2:0] overflow_divider_select;

    assign mode0 = dtc_mode_e'(timer_mode_register[MODE_T0_LSB +: 2]);
    assign mode1 = dtc_mode_e'(timer_mode_register[MODE_T1_LSB +: 2]);
    assign timer0_counter_select   = timer_mode_register[MODE_T0_LSB + MODE_CT_BIT];
    assign timer0_gate_select      = timer_mode_register[MODE_T0_LSB + MODE_GATE];
    assign timer1_counter_select   = timer_mode_register[MODE_T1_LSB + MODE_CT_BIT];
    assign timer1_gate_select      = timer_mode_register[MODE_T1_LSB + MODE_GATE];
    assign timer0_run_bit          = timer_control_register[CTL_TR0];
    assign timer1_run_bit          = timer_control_register[CTL_TR1];
    assign timer0_overflow_flag    = timer_control_register[CTL_TF0];
    assign timer1_overflow_flag    = timer_control_register[CTL_TF1];
    assign overflow_divider_select = scheduler_clock_register[SCH_DIV_LSB +: 3];

    // ------------------------------------------------------------------
    // Ticks and pins
    // ------------------------------------------------------------------
    logic [1:0] pcy_tick;
    logic [1:0] fast_sel;
    logic [1:0] count_pin;
    logic [1:0] gate_pin;
    logic [1:0] gate_level;
    logic [1:0] count_fall;

    assign fast_sel  = {clock_control_register[CKC_T1_FAST], clock_control_register[CKC_T0_FAST]};
    assign count_pin = {count_pin1, count_pin0};
    assign gate_pin  = {external_gate_pin1, external_gate_pin0};

    for (genvar i = 0; i < 2; i++) begin : g_timer
        dtc_pcy_tick u_tick (
            .clock             (clock),
            .sys_rst           (sys_rst),
            .fast_clock_sel    (fast_sel[i]),
            .double_speed_mode (double_speed_mode),
            .pcy_tick          (pcy_tick[i])
        );
        dtc_pin_sampler u_count (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .pin         (count_pin[i]),
            .sample_tick (pcy_tick[i]),
            .level       (),
            .fall        (count_fall[i])
        );
        dtc_pin_sampler u_gate (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .pin         (gate_pin[i]),
            .sample_tick (pcy_tick[i]),
            .level       (gate_level[i]),
            .fall        ()
        );
    end

    // ------------------------------------------------------------------
    // Count enables
    // ------------------------------------------------------------------
    logic t0_split;
    logic t1_halt;
    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc0_high;

    assign t0_split = (mode0 == MODE_SPLIT);
    assign t1_halt  = (mode1 == MODE_SPLIT);
    // While timer 0 is split, timer 1 loses its run bit and runs whenever its gate allows, unless it is split too.
    assign run0 = timer0_run_bit & (~timer0_gate_select | gate_level[0]);
    assign run1 = (t0_split | timer1_run_bit)
                  & (~timer1_gate_select | gate_level[1]);
    assign inc0 = run0 & (timer0_counter_select ? count_fall[0] : pcy_tick[0]);
    assign inc1 = run1 & ~t1_halt
                  & (timer1_counter_select ? count_fall[1] : pcy_tick[1]);
    assign inc0_high = t0_split & timer1_run_bit & pcy_tick[0];

    // ------------------------------------------------------------------
    // Next count values
    // ------------------------------------------------------------------
    logic [16:0] step0;
    logic [16:0] step1;
    logic [8:0]  high0_split;
    logic [7:0]  next_t0_high;
    logic        ovf0;
    logic        ovf1;
    logic [6:0]  div_mask;
    logic        div_hit;
    logic        set_tf0;
    logic        set_tf1;

    assign step0       = dtc_step(mode0, timer0_count_high, timer0_count_low, inc0);
    assign step1       = dtc_step(mode1, timer1_count_high, timer1_count_low, inc1);
    assign high0_split = {1'b0, timer0_count_high} + 9'h001;
    assign next_t0_high = t0_split ? (inc0_high ? high0_split[7:0] : timer0_count_high)
                                   : step0[15:8];
    assign ovf0 = step0[16];
    assign ovf1 = t0_split ? (inc0_high & high0_split[8]) : step1[16];

    // A zero select gives a zero mask, so every overflow passes.
    assign div_mask = 7'((8'h01 << overflow_divider_select) - 8'h01);
    assign div_hit  = ovf0 & (div_count == div_mask);
    assign set_tf0  = div_hit;
    assign set_tf1  = ovf1;

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    logic wr_mode;
    logic wr_ctl;
    logic wr_ckc;
    logic wr_sch;
    logic wr_t0l;
    logic wr_t0h;
    logic wr_t1l;
    logic wr_t1h;
    logic [7:0] ctl_base;
    logic [7:0] next_control;

    assign wr_mode = reg_wr & (reg_addr == ADDR_MODE);
    assign wr_ctl  = reg_wr & (reg_addr == ADDR_CONTROL);
    assign wr_ckc  = reg_wr & (reg_addr == ADDR_CLOCK_CTL);
    assign wr_sch  = reg_wr & (reg_addr == ADDR_SCHED_CLK);
    assign wr_t0l  = reg_wr & (reg_addr == ADDR_T0_LOW);
    assign wr_t0h  = reg_wr & (reg_addr == ADDR_T0_HIGH);
    assign wr_t1l  = reg_wr & (reg_addr == ADDR_T1_LOW);
    assign wr_t1h  = reg_wr & (reg_addr == ADDR_T1_HIGH);

    // Service acknowledge clears a flag; a fresh overflow in the same cycle wins.
    assign ctl_base = wr_ctl ? reg_wdata : timer_control_register;
    always_comb begin
        next_control = ctl_base;
        if (timer0_irq_ack) begin
            next_control[CTL_TF0] = 1'b0;
        end
        if (timer1_irq_ack) begin
            next_control[CTL_TF1] = 1'b0;
        end
        if (set_tf0) begin
            next_control[CTL_TF0] = 1'b1;
        end
        if (set_tf1) begin
            next_control[CTL_TF1] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;

    assign rd_mux = (reg_addr == ADDR_MODE)      ? timer_mode_register      :
                    (reg_addr == ADDR_CONTROL)   ? timer_control_register   :
                    (reg_addr == ADDR_CLOCK_CTL) ? clock_control_register   :
                    (reg_addr == ADDR_SCHED_CLK) ? scheduler_clock_register :
                    (reg_addr == ADDR_T0_LOW)    ? timer0_count_low         :
                    (reg_addr == ADDR_T0_HIGH)   ? timer0_count_high        :
                    (reg_addr == ADDR_T1_LOW)    ? timer1_count_low         :
                    (reg_addr == ADDR_T1_HIGH)   ? timer1_count_high        : 8'h00;

    assign timer0_irq_req = timer0_overflow_flag;
    assign timer1_irq_req = timer1_overflow_flag;

    // ------------------------------------------------------------------
    // Configuration and read data
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timer_mode_register      <= RST_BYTE;
            timer_control_register   <= RST_BYTE;
            clock_control_register   <= RST_BYTE;
            scheduler_clock_register <= RST_BYTE;
            reg_rdata                <= RST_BYTE;
        end else begin
            if (wr_mode) begin
                timer_mode_register <= reg_wdata;
            end
            if (wr_ckc) begin
                clock_control_register <= reg_wdata;
            end
            if (wr_sch) begin
                scheduler_clock_register <= reg_wdata;
            end
            timer_control_register <= next_control;
            // Counts are readable at any moment; data stand one cycle only.
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    // Writes beat counting; presetting a running timer is the caller's hazard.
    // Nothing here clears the counts when run is set.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timer0_count_low  <= RST_BYTE;
            timer0_count_high <= RST_BYTE;
            timer1_count_low  <= RST_BYTE;
            timer1_count_high <= RST_BYTE;
            div_count         <= RST_DIV;
        end else begin
            timer0_count_low  <= wr_t0l ? reg_wdata : step0[7:0];
            timer0_count_high <= wr_t0h ? reg_wdata : next_t0_high;
            timer1_count_low  <= wr_t1l ? reg_wdata : step1[7:0];
            timer1_count_high <= wr_t1h ? reg_wdata : step1[15:8];
            if (ovf0) begin
                div_count <= div_hit ? RST_DIV : div_count + 7'h01;
            end
        end
    end

endmodule

// >>> sim/dtc_timers_asserts.sv
// Checker for the register port and flag outputs of the dual timer/counter.
// Assumes it is bound to dtc_timers and sees only its ports.
`timescale 1ns/100ps
module dtc_timers_chk
    import dtc_pkg::*;
(
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       timer0_irq_ack,
    input wire logic       timer1_irq_ack,
    input wire logic       timer0_irq_req,
    input wire logic       timer1_irq_req
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence wr_rd(logic [3:0] a);
        reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside the answer cycle");
    unmapped_zero_a: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    tf0_read_a: assert property (reg_rd && reg_addr == ADDR_CONTROL |=>
        reg_rdata[CTL_TF0] == $past(timer0_irq_req)) else $error("flag 0 read mismatch");
    tf1_read_a: assert property (reg_rd && reg_addr == ADDR_CONTROL |=>
        reg_rdata[CTL_TF1] == $past(timer1_irq_req)) else $error("flag 1 read mismatch");
    mode_back_a: assert property (wr_rd(ADDR_MODE) |=>
        reg_rdata == $past(reg_wdata, 2)) else $error("mode register readback wrong");
    sched_back_a: assert property (wr_rd(ADDR_SCHED_CLK) |=>
        reg_rdata[2:0] == $past(reg_wdata[2:0], 2)) else $error("divider select wrong");
    tf0_fall_a: assert property ($fell(timer0_irq_req) |-> $past(timer0_irq_ack) ||
        $past(reg_wr && reg_addr == ADDR_CONTROL && !reg_wdata[CTL_TF0]))
        else $error("flag 0 cleared without cause");
    tf1_fall_a: assert property ($fell(timer1_irq_req) |-> $past(timer1_irq_ack) ||
        $past(reg_wr && reg_addr == ADDR_CONTROL && !reg_wdata[CTL_TF1]))
        else $error("flag 1 cleared without cause");
endmodule
bind dtc_timers dtc_timers_chk dtc_timers_chk_inst (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer0_irq_ack(timer0_irq_ack), .timer1_irq_ack(timer1_irq_ack),
    .timer0_irq_req(timer0_irq_req), .timer1_irq_req(timer1_irq_req));

// >>> sim/dtc_pin_model.sv
// Far-side model: drivers of both count pins and both gate pins.
// Assumes callers start it just after a rising clock edge.
`timescale 1ns/100ps
module dtc_pin_model (
    input  wire logic       clock,
    output logic      [1:0] count_pin,
    output logic      [1:0] gate_pin
);
    initial begin
        count_pin = 2'b11;
        gate_pin = 2'b00;
    end
    // Each level is held for hold cycles, at least one peripheral cycle.
    task automatic send_edges(input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            repeat (hold) @(posedge clock);
            count_pin <= 2'b00;
            repeat (hold) @(posedge clock);
            count_pin <= 2'b11;
        end
    endtask
    task automatic set_gate(input logic v);
        gate_pin <= {2{v}};
        @(posedge clock);
    endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the dual timer/counter.
// Assumes the design, its checker and the pin model are compiled first.
`timescale 1ns/100ps
module tb;
    import dtc_pkg::*;
    logic       clock;
    logic       sys_rst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       double_speed_mode;
    logic [1:0] count_pin;
    logic [1:0] gate_pin;
    logic [1:0] irq_ack;
    logic [1:0] irq_req;
    logic [7:0] rd;
    logic [7:0] held;
    int         num_errors;
    int         checked;
    int         cycles;
    dtc_timers dtc_timers_inst (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .double_speed_mode(double_speed_mode), .count_pin0(count_pin[0]),
        .count_pin1(count_pin[1]), .external_gate_pin0(gate_pin[0]),
        .external_gate_pin1(gate_pin[1]), .timer0_irq_ack(irq_ack[0]),
        .timer1_irq_ack(irq_ack[1]), .timer0_irq_req(irq_req[0]), .timer1_irq_req(irq_req[1]));
    dtc_pin_model dtc_pin_model_inst (.clock(clock), .count_pin(count_pin), .gate_pin(gate_pin));
    // ------------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------------
    // A write waits one edge first, so two writes never touch the strobe in one step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rdb(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        rd = reg_rdata;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic ack(input logic [1:0] m);
        irq_ack <= m;
        @(posedge clock);
        irq_ack <= 2'b00;
        repeat (2) @(posedge clock);
        chk("flags after ack", 8'h00, {6'h00, irq_req & m});
    endtask
    // Presets timer 0, runs it, times the flag and reads the count once stopped.
    task automatic run0(input logic [7:0] md, input logic ds, input logic [7:0] ckc,
        input logic [7:0] dv, input logic [7:0] hi, input logic [7:0] lo, input int exp,
        input logic [7:0] elo, input logic [7:0] ehi);
        int n;
        double_speed_mode <= ds;
        wr(ADDR_MODE, md);
        wr(ADDR_CLOCK_CTL, ckc);
        wr(ADDR_SCHED_CLK, dv);
        wr(ADDR_T0_HIGH, hi);
        wr(ADDR_T0_LOW, lo);
        wr(ADDR_CONTROL, 8'h10);
        n = 0;
        while (irq_req[0] !== 1'b1 && n < exp + 20) begin
            @(posedge clock);
            n++;
        end
        wr(ADDR_CONTROL, 8'h20);
        chk("overflow time", 8'h01, {7'h00, n >= exp - 14 && n <= exp + 3});
        rdb(ADDR_T0_LOW);
        chk("low count", elo, rd);
        rdb(ADDR_T0_HIGH);
        chk("high count", ehi, rd);
        ack(2'b01);
    endtask
    task automatic stop_test;
        $display("Errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, double_speed_mode, irq_ack} = '0;
        {num_errors, checked, cycles} = '0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            rdb(a == 8 ? 4'hC : 4'(a));
            chk("reset value", RST_BYTE, rd);
        end
        wr(ADDR_MODE, 8'hA5);
        rdb(ADDR_MODE);
        chk("mode readback", 8'hA5, rd);
        wr(ADDR_SCHED_CLK, 8'h05);
        rdb(ADDR_SCHED_CLK);
        chk("divider readback", 8'h05, rd);
        wr(ADDR_CONTROL, 8'hA0);
        rdb(ADDR_CONTROL);
        chk("control readback", 8'hA0, rd);
        chk("flags set by write", 8'h03, {6'h00, irq_req});
        ack(2'b11);
        run0(8'h00, 1'b0, 8'h00, 8'h00, 8'hFF, 8'h10, 192, 8'h00, 8'h00);
        run0(8'h01, 1'b1, 8'h00, 8'h00, 8'hFF, 8'hF0, 96, 8'h00, 8'h00);
        run0(8'h01, 1'b1, 8'h01, 8'h00, 8'hFF, 8'hF0, 192, 8'h00, 8'h00);
        run0(8'h02, 1'b0, 8'h00, 8'h03, 8'hF0, 8'hF0, 1536, 8'hF0, 8'hF0);
        run0(8'h03, 1'b0, 8'h00, 8'h00, 8'hFF, 8'hF0, 192, 8'h00, 8'hFF);
        run0(8'h02, 1'b1, 8'h00, 8'h07, 8'hF0, 8'hF0, 12288, 8'hF0, 8'hF0);
        double_speed_mode <= 1'b0;
        // Split mode: the high byte runs on timer 1's run bit and raises timer 1's flag.
        wr(ADDR_MODE, 8'h03);
        wr(ADDR_T0_HIGH, 8'hFF);
        wr(ADDR_CONTROL, 8'h40);
        repeat (20) @(posedge clock);
        chk("split high flag", 8'h02, {6'h00, irq_req});
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_MODE, 8'h55);
        wr(ADDR_T0_LOW, 8'h00);
        wr(ADDR_T1_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h50);
        dtc_pin_model_inst.send_edges(5, 14);
        repeat (40) @(posedge clock);
        wr(ADDR_CONTROL, 8'h00);
        rdb(ADDR_T0_LOW);
        chk("counted edges 0", 8'h05, rd);
        rdb(ADDR_T1_LOW);
        chk("counted edges 1", 8'h05, rd);
        for (int g = 0; g < 2; g++) begin
            dtc_pin_model_inst.set_gate(g[0]);
            wr(ADDR_MODE, 8'h99);
            wr(ADDR_CONTROL, 8'h50);
            repeat (100) @(posedge clock);
            wr(ADDR_CONTROL, 8'h00);
            rdb(ADDR_T0_LOW);
            chk("gated count moved", {7'h00, g[0]}, {7'h00, rd !== 8'h05});
        end
        wr(ADDR_MODE, 8'h30);
        rdb(ADDR_T1_LOW);
        held = rd;
        wr(ADDR_CONTROL, 8'h40);
        repeat (100) @(posedge clock);
        rdb(ADDR_T1_LOW);
        chk("held count", held, rd);
        stop_test();
    end
endmodule
